// ---- verification/data_cache_management_ops_test.sv ----
module data_cache_management_ops_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                         clk_sys = 1'b0;
	logic                         rst = 1'b1;
	logic                         opValid = 1'b0;
	dcache_mgmt_pkg::dcache_op_e  opCode = dcache_mgmt_pkg::OP_ALLOC;
	logic [31:0]                  opAddr = 32'h0000_0000;
	logic                         opPriv = 1'b0;
	logic                         tlbValid = 1'b1;
	logic                         tlbRead = 1'b1;
	logic                         tlbInhibit = 1'b0;
	logic                         guaranteedTouch = 1'b0;
	logic                         forcedMiss = 1'b0;
	logic [2:0]                   fillBufBusy = 3'h0;
	logic                         laterAccessPending = 1'b0;
	logic                         rdAck, wrAck, rdReq, wrReq;
	logic [255:0]                 rdData, wrData, lastWrData;
	logic [31:0]                  rdAddr, wrAddr, lastRdAddr, lastWrAddr;
	logic                         busy, opDone, opPrivErr, touchDropped;
	logic [31:0]                  gprData, tagHigh, tagLow;
	int                           rdCount, wrCount, rdN, wrN, err_count, compares;
	logic                         privSeen, dropSeen;
	logic [31:0]                  adr [5];
	logic [31:0]                  t;

	always #25 clk_sys = ~clk_sys;

	data_cache_controller i_data_cache_controller (
		.clk_sys(clk_sys), .rst(rst), .opValid(opValid), .opCode(opCode), .opAddr(opAddr),
		.opPriv(opPriv), .tlbValid(tlbValid), .tlbRead(tlbRead), .tlbInhibit(tlbInhibit),
		.guaranteedTouch(guaranteedTouch), .forcedMiss(forcedMiss), .fillBufBusy(fillBufBusy),
		.laterAccessPending(laterAccessPending), .rdAck(rdAck), .rdData(rdData), .wrAck(wrAck),
		.busy(busy), .opDone(opDone), .opPrivErr(opPrivErr), .touchDropped(touchDropped),
		.rdReq(rdReq), .rdAddr(rdAddr), .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData),
		.gprData(gprData), .tagHigh(tagHigh), .tagLow(tagLow));

	mem_bus_model i_mem_bus_model (
		.clk_sys(clk_sys), .rst(rst), .rdReq(rdReq), .rdAddr(rdAddr), .wrReq(wrReq),
		.wrAddr(wrAddr), .wrData(wrData), .rdAck(rdAck), .rdData(rdData), .wrAck(wrAck),
		.rdCount(rdCount), .wrCount(wrCount), .lastRdAddr(lastRdAddr),
		.lastWrAddr(lastWrAddr), .lastWrData(lastWrData));

	function automatic logic [31:0] lineWord(input logic [31:0] a, input logic [2:0] n);
		return {a[31:5], 5'h00} + {29'h0, n};
	endfunction : lineWord

	task automatic chkVal(input string what, input logic [255:0] exp, input logic [255:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chkVal

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic doOp(input dcache_mgmt_pkg::dcache_op_e c, input logic [31:0] a,
			input logic p);
		int rdBase;
		int wrBase;
		int k;
		rdBase = rdCount;
		wrBase = wrCount;
		@(posedge clk_sys);
		opValid <= 1'b1;
		opCode <= c;
		opAddr <= a;
		opPriv <= p;
		@(posedge clk_sys);
		opValid <= 1'b0;
		opAddr <= {$urandom()};
		for (k = 0; k < 300; k++) begin
			@(posedge clk_sys);
			#1;
			if (opDone === 1'b1) break;
		end
		chkVal("opDone", 1, k < 300);
		privSeen = opPrivErr;
		dropSeen = touchDropped;
		rdN = rdCount - rdBase;
		wrN = wrCount - wrBase;
	endtask : doOp

	// one management op, then its bus traffic and completion flags
	task automatic runOp(input dcache_mgmt_pkg::dcache_op_e c, input logic [31:0] a,
			input logic p, input int eRd, input int eWr, input logic ePriv, input logic eDrop);
		doOp(c, a, p);
		chkVal("reads", eRd, rdN);
		chkVal("writes", eWr, wrN);
		chkVal("opPrivErr", ePriv, privSeen);
		chkVal("touchDropped", eDrop, dropSeen);
		chkVal("busy", 0, busy);
	endtask : runOp

	// debug read of the line of a held in way w
	task automatic chkDbg(input logic [5:0] w, input logic [31:0] a, input logic v,
			input logic [3:0] d, input logic z);
		runOp(dcache_mgmt_pkg::OP_DEBUG_READ, {17'h0, w, a[8:5], a[4:2], 2'b00}, 1'b1,
			0, 0, 1'b0, 1'b0);
		chkVal("tagHigh", v ? {a[31:9], 8'h00, 1'b1} : 32'h0000_0000, tagHigh & {31'h0, 1'b1}
			| (v ? tagHigh & 32'hFFFF_FFFE : 32'h0000_0000));
		chkVal("tagLow", {28'h0, d}, tagLow);
		if (v) chkVal("gprData", z ? 32'h0000_0000 : lineWord(a, a[4:2]), gprData);
	endtask : chkDbg

	task automatic endTest(input string name);
		$display("test %s done, mismatches so far %0d", name, err_count);
	endtask : endTest

	initial begin
		#(50 * 30000);
		err_count++;
		complete_run();
	end

	initial begin
		err_count = 0;
		compares = 0;
		void'($urandom(53));
		for (int i = 0; i < 5; i++) begin
			t = $urandom();
			adr[i] = {t[31:9], 4'(i * 3 + 1), t[4:2], 2'b00};
		end
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		runOp(dcache_mgmt_pkg::OP_ALLOC, adr[0], 1'b1, 0, 0, 1'b0, 1'b0);
		runOp(dcache_mgmt_pkg::OP_INVAL, adr[0], 1'b0, 0, 0, 1'b1, 1'b0);
		runOp(dcache_mgmt_pkg::OP_INVAL_ALL, adr[0], 1'b0, 0, 0, 1'b1, 1'b0);
		runOp(dcache_mgmt_pkg::OP_DEBUG_READ, 32'h0000_0000, 1'b0, 0, 0, 1'b1, 1'b0);
		endTest("nop and privilege");
		tlbInhibit <= 1'b1;
		runOp(dcache_mgmt_pkg::OP_TOUCH, adr[0], 1'b0, 0, 0, 1'b0, 1'b0);
		tlbInhibit <= 1'b0;
		tlbRead <= 1'b0;
		runOp(dcache_mgmt_pkg::OP_TOUCH_ST, adr[0], 1'b0, 0, 0, 1'b0, 1'b0);
		tlbRead <= 1'b1;
		endTest("untranslated touch");
		runOp(dcache_mgmt_pkg::OP_TOUCH, adr[0], 1'b0, 1, 0, 1'b0, 1'b0);
		chkVal("rdAddr", adr[0], lastRdAddr);
		chkDbg(6'h00, adr[0], 1'b1, 4'h0, 1'b0);
		runOp(dcache_mgmt_pkg::OP_TOUCH, adr[0], 1'b0, 0, 0, 1'b0, 1'b0);
		forcedMiss <= 1'b1;
		runOp(dcache_mgmt_pkg::OP_TOUCH_ST, adr[0], 1'b0, 1, 0, 1'b0, 1'b0);
		forcedMiss <= 1'b0;
		chkDbg(6'h01, adr[0], 1'b1, 4'h0, 1'b0);
		endTest("touch fill and forced miss");
		fillBufBusy <= 3'h7;
		laterAccessPending <= 1'b1;
		runOp(dcache_mgmt_pkg::OP_TOUCH, adr[1], 1'b0, 0, 0, 1'b0, 1'b1);
		runOp(dcache_mgmt_pkg::OP_TOUCH_ST, adr[1], 1'b0, 0, 0, 1'b0, 1'b1);
		guaranteedTouch <= 1'b1;
		// buffers free up only while the touch already waits, so the stall is seen
		fork
			runOp(dcache_mgmt_pkg::OP_TOUCH_ST, adr[1], 1'b0, 1, 0, 1'b0, 1'b0);
			begin
				repeat (6) @(posedge clk_sys);
				fillBufBusy <= 3'h0;
				#1;
				chkVal("busy", 1, busy);
			end
		join
		guaranteedTouch <= 1'b0;
		fillBufBusy <= 3'h0;
		laterAccessPending <= 1'b0;
		chkDbg(6'h02, adr[1], 1'b1, 4'h0, 1'b0);
		endTest("drop and guaranteed touch");
		runOp(dcache_mgmt_pkg::OP_ZERO, adr[2], 1'b0, 0, 0, 1'b0, 1'b0);
		chkDbg(6'h03, adr[2], 1'b1, 4'hF, 1'b1);
		runOp(dcache_mgmt_pkg::OP_STORE, adr[2], 1'b0, 0, 1, 1'b0, 1'b0);
		chkVal("wrAddr", {adr[2][31:5], 5'h00}, lastWrAddr);
		chkVal("wrData", 256'h0, lastWrData);
		chkDbg(6'h03, adr[2], 1'b1, 4'h0, 1'b1);
		runOp(dcache_mgmt_pkg::OP_STORE, adr[2], 1'b0, 0, 0, 1'b0, 1'b0);
		endTest("zero and store");
		runOp(dcache_mgmt_pkg::OP_ZERO, adr[3], 1'b0, 0, 0, 1'b0, 1'b0);
		runOp(dcache_mgmt_pkg::OP_INVAL, adr[3], 1'b1, 0, 0, 1'b0, 1'b0);
		chkDbg(6'h04, adr[3], 1'b0, 4'h0, 1'b1);
		runOp(dcache_mgmt_pkg::OP_FLUSH, adr[1], 1'b0, 0, 0, 1'b0, 1'b0);
		chkDbg(6'h02, adr[1], 1'b0, 4'h0, 1'b0);
		runOp(dcache_mgmt_pkg::OP_ZERO, adr[4], 1'b0, 0, 0, 1'b0, 1'b0);
		runOp(dcache_mgmt_pkg::OP_FLUSH, adr[4], 1'b0, 0, 1, 1'b0, 1'b0);
		chkVal("wrAddr", {adr[4][31:5], 5'h00}, lastWrAddr);
		chkDbg(6'h05, adr[4], 1'b0, 4'h0, 1'b1);
		endTest("invalidate and flush");
		runOp(dcache_mgmt_pkg::OP_INVAL_ALL, 32'h0000_0000, 1'b1, 0, 0, 1'b0, 1'b0);
		chkDbg(6'h01, adr[0], 1'b0, 4'h0, 1'b0);
		chkDbg(6'h03, adr[2], 1'b0, 4'h0, 1'b0);
		endTest("flash invalidate");
		// one full lap of the victim pointer, so the next victim is a dirty line
		for (int i = 0; i < 64; i++) begin
			adr[0] = {t[31:9] + 23'(i), 9'h040};
			runOp(dcache_mgmt_pkg::OP_ZERO, adr[0], 1'b0, 0, 0, 1'b0, 1'b0);
		end
		adr[1] = {t[31:9] + 23'h00_0040, 9'h044};
		runOp(dcache_mgmt_pkg::OP_TOUCH, adr[1], 1'b0, 1, 1, 1'b0, 1'b0);
		chkVal("wrAddr", {t[31:9], 9'h040}, lastWrAddr);
		chkVal("rdAddr", adr[1], lastRdAddr);
		adr[2] = {t[31:9] + 23'h00_0041, 9'h048};
		runOp(dcache_mgmt_pkg::OP_ZERO, adr[2], 1'b0, 0, 1, 1'b0, 1'b0);
		chkVal("wrAddr", {t[31:9] + 23'h00_0001, 9'h040}, lastWrAddr);
		chkDbg(6'h07, adr[2], 1'b1, 4'hF, 1'b1);
		endTest("dirty victim cast-out");
		complete_run();
	end
endmodule : data_cache_management_ops_test

// ---- verification/mem_bus_model.sv ----
module mem_bus_model (
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          rdReq,
	input  wire logic [31:0]   rdAddr,
	input  wire logic          wrReq,
	input  wire logic [31:0]   wrAddr,
	input  wire logic [255:0]  wrData,
	output logic               rdAck,
	output logic [255:0]       rdData,
	output logic               wrAck,
	output int                 rdCount,
	output int                 wrCount,
	output logic [31:0]        lastRdAddr,
	output logic [31:0]        lastWrAddr,
	output logic [255:0]       lastWrData
);
	timeunit 1ns;
	timeprecision 1ns;
	int rdWait;
	int wrWait;

	// whole line per beat; word n carries its line base plus n
	function automatic logic [255:0] lineOf(input logic [31:0] a);
		logic [255:0] l;
		for (int n = 0; n < 8; n++) begin
			l[32*n +: 32] = {a[31:5], 5'h00} + 32'(n);
		end
		return l;
	endfunction : lineOf

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdAck <= 1'b0;
			wrAck <= 1'b0;
			rdData <= '0;
			rdCount <= 0;
			wrCount <= 0;
			rdWait <= 0;
			wrWait <= 0;
			lastRdAddr <= 32'h0000_0000;
			lastWrAddr <= 32'h0000_0000;
			lastWrData <= '0;
		end else begin
			rdAck <= 1'b0;
			wrAck <= 1'b0;
			// outside the ack cycle the data lines carry noise, never stale data
			rdData <= {8{$urandom()}};
			if (rdReq && !rdAck) begin
				if (rdWait == 0) begin
					rdAck <= 1'b1;
					rdData <= lineOf(rdAddr);
					rdCount <= rdCount + 1;
					lastRdAddr <= rdAddr;
					rdWait <= $urandom_range(3, 0);
				end else begin
					rdWait <= rdWait - 1;
				end
			end
			if (wrReq && !wrAck) begin
				if (wrWait == 0) begin
					wrAck <= 1'b1;
					wrCount <= wrCount + 1;
					lastWrAddr <= wrAddr;
					lastWrData <= wrData;
					wrWait <= $urandom_range(3, 0);
				end else begin
					wrWait <= wrWait - 1;
				end
			end
		end
	end
endmodule : mem_bus_model

// ---- verilog/data_cache_controller.sv ----
module data_cache_controller (
	input  wire logic                                 clk_sys,
	input  wire logic                                 rst,
	input  wire logic                                 opValid,
	input  wire dcache_mgmt_pkg::dcache_op_e          opCode,
	input  wire logic [dcache_mgmt_pkg::ADDR_W-1:0]   opAddr,
	input  wire logic                                 opPriv,
	input  wire logic                                 tlbValid,
	input  wire logic                                 tlbRead,
	input  wire logic                                 tlbInhibit,
	input  wire logic                                 guaranteedTouch,
	input  wire logic                                 forcedMiss,
	input  wire logic [dcache_mgmt_pkg::LFB_COUNT-1:0] fillBufBusy,
	input  wire logic                                 laterAccessPending,
	input  wire logic                                 rdAck,
	input  wire logic [dcache_mgmt_pkg::LINE_BITS-1:0] rdData,
	input  wire logic                                 wrAck,
	output logic                                      busy,
	output logic                                      opDone,
	output logic                                      opPrivErr,
	output logic                                      touchDropped,
	output logic                                      rdReq,
	output logic [dcache_mgmt_pkg::ADDR_W-1:0]        rdAddr,
	output logic                                      wrReq,
	output logic [dcache_mgmt_pkg::ADDR_W-1:0]        wrAddr,
	output logic [dcache_mgmt_pkg::LINE_BITS-1:0]     wrData,
	output logic [dcache_mgmt_pkg::WORD_W-1:0]        gprData,
	output logic [dcache_mgmt_pkg::WORD_W-1:0]        tagHigh,
	output logic [dcache_mgmt_pkg::WORD_W-1:0]        tagLow
);
	// no snoop port exists: foreign writes and reads are never observed
	function automatic logic [dcache_mgmt_pkg::IDX_W-1:0] lineIdx(
		input logic [dcache_mgmt_pkg::WAY_W-1:0] way,
		input logic [dcache_mgmt_pkg::ADDR_W-1:0] addr
	);
		lineIdx = {way, addr[dcache_mgmt_pkg::SET_LSB +: dcache_mgmt_pkg::SET_W]};
	endfunction : lineIdx

	function automatic logic [dcache_mgmt_pkg::ADDR_W-1:0] lineBase(
		input logic [dcache_mgmt_pkg::TAG_W-1:0] tag,
		input logic [dcache_mgmt_pkg::IDX_W-1:0] idx
	);
		lineBase = {tag, idx[dcache_mgmt_pkg::SET_W-1:0], 5'h00};
	endfunction : lineBase

	logic [dcache_mgmt_pkg::TAG_W-1:0]     tagMem   [dcache_mgmt_pkg::LINES];
	logic [dcache_mgmt_pkg::LINE_BITS-1:0] dataMem  [dcache_mgmt_pkg::LINES];
	logic [dcache_mgmt_pkg::DW_COUNT-1:0]  dirtyMem [dcache_mgmt_pkg::LINES];

	dcache_mgmt_pkg::ctrl_state_e          stateQ,   stateD;
	dcache_mgmt_pkg::dcache_op_e           opQ,      opD;
	logic [dcache_mgmt_pkg::ADDR_W-1:0]    addrQ,    addrD;
	logic                                  privQ,    privD;
	logic                                  xlateOkQ, xlateOkD;
	logic [dcache_mgmt_pkg::IDX_W-1:0]     tgtQ,     tgtD;
	logic [dcache_mgmt_pkg::WAY_W-1:0]     victimQ,  victimD;
	logic [dcache_mgmt_pkg::LINES-1:0]     validQ,   validD;
	logic                                  busyQ,    busyD;
	logic                                  doneQ,    doneD;
	logic                                  privErrQ, privErrD;
	logic                                  dropQ,    dropD;
	logic                                  rdReqQ,   rdReqD;
	logic                                  wrReqQ,   wrReqD;
	logic [dcache_mgmt_pkg::ADDR_W-1:0]    wrAddrQ,  wrAddrD;
	logic [dcache_mgmt_pkg::LINE_BITS-1:0] wrDataQ,  wrDataD;
	logic [dcache_mgmt_pkg::WORD_W-1:0]    gprQ,     gprD;
	logic [dcache_mgmt_pkg::WORD_W-1:0]    tagHiQ,   tagHiD;
	logic [dcache_mgmt_pkg::WORD_W-1:0]    tagLoQ,   tagLoD;

	logic                                  lineWe;
	logic                                  dirtyWe;
	logic [dcache_mgmt_pkg::IDX_W-1:0]     memIdx;
	logic [dcache_mgmt_pkg::LINE_BITS-1:0] memData;
	logic [dcache_mgmt_pkg::DW_COUNT-1:0]  memDirty;

	logic [dcache_mgmt_pkg::WAYS-1:0]      hitVec;
	logic                                  hit;
	logic [dcache_mgmt_pkg::WAY_W-1:0]     hitWay;
	logic [dcache_mgmt_pkg::IDX_W-1:0]     hitIdx;
	logic [dcache_mgmt_pkg::IDX_W-1:0]     vicIdx;
	logic [dcache_mgmt_pkg::IDX_W-1:0]     dbgIdx;
	logic                                  isTouch;
	logic                                  needPriv;

	for (genvar w = 0; w < dcache_mgmt_pkg::WAYS; w++) begin : g_cmp
		localparam logic [dcache_mgmt_pkg::WAY_W-1:0] WAY_ID = w[dcache_mgmt_pkg::WAY_W-1:0];
		assign hitVec[w] = validQ[lineIdx(WAY_ID, addrQ)]
			&& tagMem[lineIdx(WAY_ID, addrQ)] == addrQ[dcache_mgmt_pkg::TAG_LSB +:
			dcache_mgmt_pkg::TAG_W];
	end

	always_comb begin
		hitWay = '0;
		for (int i = dcache_mgmt_pkg::WAYS - 1; i >= 0; i--) begin
			if (hitVec[i]) begin
				hitWay = i[dcache_mgmt_pkg::WAY_W-1:0];
			end
		end
	end

	assign hit      = |hitVec;
	assign hitIdx   = lineIdx(hitWay, addrQ);
	assign vicIdx   = lineIdx(victimQ, addrQ);
	assign dbgIdx   = lineIdx(addrQ[dcache_mgmt_pkg::WAY_LSB +: dcache_mgmt_pkg::WAY_W], addrQ);
	// both touch flavours share one path
	assign isTouch  = opQ == dcache_mgmt_pkg::OP_TOUCH || opQ == dcache_mgmt_pkg::OP_TOUCH_ST;
	assign needPriv = opQ == dcache_mgmt_pkg::OP_INVAL || opQ == dcache_mgmt_pkg::OP_INVAL_ALL
		|| opQ == dcache_mgmt_pkg::OP_DEBUG_READ;

	always_comb begin
		stateD   = stateQ;
		opD      = opQ;
		addrD    = addrQ;
		privD    = privQ;
		xlateOkD = xlateOkQ;
		tgtD     = tgtQ;
		victimD  = victimQ;
		validD   = validQ;
		busyD    = busyQ;
		doneD    = 1'b0;
		privErrD = 1'b0;
		dropD    = 1'b0;
		rdReqD   = rdReqQ;
		wrReqD   = wrReqQ;
		wrAddrD  = wrAddrQ;
		wrDataD  = wrDataQ;
		gprD     = gprQ;
		tagHiD   = tagHiQ;
		tagLoD   = tagLoQ;
		lineWe   = 1'b0;
		dirtyWe  = 1'b0;
		memIdx   = tgtQ;
		memData  = dcache_mgmt_pkg::LINE_ZERO;
		memDirty = dcache_mgmt_pkg::DIRTY_NONE;
		unique case (stateQ)
			dcache_mgmt_pkg::ST_IDLE: begin
				if (opValid) begin
					opD      = opCode;
					addrD    = opAddr;
					privD    = opPriv;
					xlateOkD = tlbValid && tlbRead && !tlbInhibit;
					busyD    = 1'b1;
					stateD   = dcache_mgmt_pkg::ST_LOOK;
				end
			end
			dcache_mgmt_pkg::ST_LOOK: begin
				stateD = dcache_mgmt_pkg::ST_IDLE;
				busyD  = 1'b0;
				doneD  = 1'b1;
				if (needPriv && !privQ) begin
					privErrD = 1'b1;
				end else begin
					unique case (opQ)
						dcache_mgmt_pkg::OP_ALLOC: begin
						end // nothing touched
						dcache_mgmt_pkg::OP_FLUSH, dcache_mgmt_pkg::OP_STORE: begin
							if (hit && dirtyMem[hitIdx] != dcache_mgmt_pkg::DIRTY_NONE) begin
								tgtD    = hitIdx; // whole line only
								wrReqD  = 1'b1;
								wrAddrD = lineBase(tagMem[hitIdx], hitIdx);
								wrDataD = dataMem[hitIdx];
								stateD  = dcache_mgmt_pkg::ST_CAST;
								busyD   = 1'b1;
								doneD   = 1'b0;
							end else if (hit && opQ == dcache_mgmt_pkg::OP_FLUSH) begin
								validD[hitIdx] = 1'b0;
							end
						end
						dcache_mgmt_pkg::OP_INVAL: begin
							if (hit) begin
								validD[hitIdx] = 1'b0; // dirty data dropped, no write
								dirtyWe        = 1'b1;
								memIdx         = hitIdx;
							end
						end
						dcache_mgmt_pkg::OP_INVAL_ALL: begin
							validD = '0;
						end
						dcache_mgmt_pkg::OP_DEBUG_READ: begin
							gprD   = dataMem[dbgIdx][addrQ[dcache_mgmt_pkg::WORD_LSB +: 3]*32 +: 32];
							tagHiD = {tagMem[dbgIdx], 8'h00, validQ[dbgIdx]};
							tagLoD = {28'h000_0000, dirtyMem[dbgIdx]};
						end
						dcache_mgmt_pkg::OP_ZERO: begin
							tgtD = hit ? hitIdx : vicIdx;
							if (!hit && validQ[vicIdx]
								&& dirtyMem[vicIdx] != dcache_mgmt_pkg::DIRTY_NONE) begin
								wrReqD  = 1'b1;
								wrAddrD = lineBase(tagMem[vicIdx], vicIdx);
								wrDataD = dataMem[vicIdx];
								stateD  = dcache_mgmt_pkg::ST_CAST;
								busyD   = 1'b1;
								doneD   = 1'b0;
							end else begin
								lineWe   = 1'b1; // no memory read
								dirtyWe  = 1'b1;
								memIdx   = hit ? hitIdx : vicIdx;
								memDirty = dcache_mgmt_pkg::DIRTY_ALL;
								validD[memIdx] = 1'b1;
								victimD  = hit ? victimQ : victimQ + 6'h01;
							end
						end
						default: begin // touch variants
							if (!xlateOkQ || (hit && !forcedMiss)) begin
							end // quiet end
							else if (&fillBufBusy) begin
								if (!guaranteedTouch && laterAccessPending) begin
									dropD = 1'b1;
								end else begin
									// holding here stalls the pipeline
									stateD = dcache_mgmt_pkg::ST_LOOK;
									busyD  = 1'b1;
									doneD  = 1'b0;
								end
							end else begin
								tgtD   = vicIdx; // a hit under forced miss duplicates
								busyD  = 1'b1;
								doneD  = 1'b0;
								if (validQ[vicIdx]
									&& dirtyMem[vicIdx] != dcache_mgmt_pkg::DIRTY_NONE) begin
									wrReqD  = 1'b1;
									wrAddrD = lineBase(tagMem[vicIdx], vicIdx);
									wrDataD = dataMem[vicIdx];
									stateD  = dcache_mgmt_pkg::ST_CAST;
								end else begin
									rdReqD = 1'b1;
									stateD = dcache_mgmt_pkg::ST_FILL;
								end
							end
						end
					endcase
				end
			end
			dcache_mgmt_pkg::ST_CAST: begin
				if (wrAck) begin
					wrReqD = 1'b0;
					if (isTouch) begin
						validD[tgtQ] = 1'b0;
						rdReqD       = 1'b1;
						stateD       = dcache_mgmt_pkg::ST_FILL;
					end else begin
						stateD  = dcache_mgmt_pkg::ST_IDLE;
						busyD   = 1'b0;
						doneD   = 1'b1;
						dirtyWe = 1'b1;
						if (opQ == dcache_mgmt_pkg::OP_FLUSH) begin
							validD[tgtQ] = 1'b0;
						end else if (opQ == dcache_mgmt_pkg::OP_ZERO) begin
							lineWe       = 1'b1;
							memDirty     = dcache_mgmt_pkg::DIRTY_ALL;
							validD[tgtQ] = 1'b1;
							victimD      = victimQ + 6'h01;
						end
					end
				end
			end
			dcache_mgmt_pkg::ST_FILL: begin
				if (rdAck) begin
					rdReqD       = 1'b0;
					lineWe       = 1'b1;
					dirtyWe      = 1'b1;
					memData      = rdData;
					validD[tgtQ] = 1'b1;
					victimD      = victimQ + 6'h01;
					stateD       = dcache_mgmt_pkg::ST_IDLE;
					busyD        = 1'b0;
					doneD        = 1'b1;
				end
			end
		endcase
	end

	// arrays have no reset: validity alone decides whether a line counts
	always_ff @(posedge clk_sys) begin
		if (lineWe) begin
			dataMem[memIdx] <= memData;
			tagMem[memIdx]  <= addrQ[dcache_mgmt_pkg::TAG_LSB +: dcache_mgmt_pkg::TAG_W];
		end
		if (dirtyWe) begin
			dirtyMem[memIdx] <= memDirty;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stateQ   <= dcache_mgmt_pkg::ST_IDLE;
			opQ      <= dcache_mgmt_pkg::OP_ALLOC;
			addrQ    <= dcache_mgmt_pkg::ADDR_RST;
			privQ    <= 1'b0;
			xlateOkQ <= 1'b0;
			tgtQ     <= '0;
			victimQ  <= dcache_mgmt_pkg::VICTIM_RST;
			validQ   <= '0;
			busyQ    <= 1'b0;
			doneQ    <= 1'b0;
			privErrQ <= 1'b0;
			dropQ    <= 1'b0;
			rdReqQ   <= 1'b0;
			wrReqQ   <= 1'b0;
			wrAddrQ  <= dcache_mgmt_pkg::ADDR_RST;
			wrDataQ  <= dcache_mgmt_pkg::LINE_ZERO;
			gprQ     <= '0;
			tagHiQ   <= '0;
			tagLoQ   <= '0;
		end else begin
			stateQ   <= stateD;
			opQ      <= opD;
			addrQ    <= addrD;
			privQ    <= privD;
			xlateOkQ <= xlateOkD;
			tgtQ     <= tgtD;
			victimQ  <= victimD;
			validQ   <= validD;
			busyQ    <= busyD;
			doneQ    <= doneD;
			privErrQ <= privErrD;
			dropQ    <= dropD;
			rdReqQ   <= rdReqD;
			wrReqQ   <= wrReqD;
			wrAddrQ  <= wrAddrD;
			wrDataQ  <= wrDataD;
			gprQ     <= gprD;
			tagHiQ   <= tagHiD;
			tagLoQ   <= tagLoD;
		end
	end

	assign busy         = busyQ;
	assign opDone       = doneQ;
	assign opPrivErr    = privErrQ;
	assign touchDropped = dropQ;
	assign rdReq        = rdReqQ;
	assign rdAddr       = addrQ; // operand address as issued, not line aligned; full line implied
	assign wrReq        = wrReqQ;
	assign wrAddr       = wrAddrQ;
	assign wrData       = wrDataQ;
	assign gprData      = gprQ;
	assign tagHigh      = tagHiQ;
	assign tagLow       = tagLoQ;

	allocNop_a: assert property (@(posedge clk_sys) disable iff (rst)
		stateQ == dcache_mgmt_pkg::ST_LOOK && opQ == dcache_mgmt_pkg::OP_ALLOC
		|=> opDone && !rdReq && !wrReq && $stable(validQ))
		else $error("allocate changed state");
	privGuard_a: assert property (@(posedge clk_sys) disable iff (rst)
		opPrivErr |-> $past(needPriv && !privQ) && $stable(validQ))
		else $error("privilege error mismatch");
	flashInval_a: assert property (@(posedge clk_sys) disable iff (rst)
		stateQ == dcache_mgmt_pkg::ST_LOOK && opQ == dcache_mgmt_pkg::OP_INVAL_ALL && privQ
		|=> validQ == '0 && opDone)
		else $error("flash invalidate missed");
	zeroNoRead_a: assert property (@(posedge clk_sys) disable iff (rst)
		opQ == dcache_mgmt_pkg::OP_ZERO |-> !rdReq)
		else $error("zero read memory");
	touchQuiet_a: assert property (@(posedge clk_sys) disable iff (rst)
		stateQ == dcache_mgmt_pkg::ST_LOOK && isTouch && !xlateOkQ
		|=> opDone && !rdReq && !opPrivErr)
		else $error("untranslated touch filled");
	dropDefault_a: assert property (@(posedge clk_sys) disable iff (rst)
		touchDropped |-> $past(&fillBufBusy && laterAccessPending && !guaranteedTouch))
		else $error("touch dropped wrongly");
	guarNoDrop_a: assert property (@(posedge clk_sys) disable iff (rst)
		stateQ == dcache_mgmt_pkg::ST_LOOK && isTouch && guaranteedTouch |=> !touchDropped)
		else $error("guaranteed touch dropped");
	fillAddr_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(rdReq) |-> isTouch && rdAddr == addrQ ##0 rdReq [*1] ##1 (rdReq || opDone))
		else $error("fill request malformed");
	writeDirty_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(wrReq) && (opQ == dcache_mgmt_pkg::OP_FLUSH || opQ == dcache_mgmt_pkg::OP_STORE)
		|-> $past(hit && dirtyMem[hitIdx] != dcache_mgmt_pkg::DIRTY_NONE))
		else $error("clean line written back");
endmodule : data_cache_controller

// ---- verilog/dcache_mgmt_pkg.sv ----
package dcache_mgmt_pkg;
	localparam int unsigned ADDR_W    = 32;
	localparam int unsigned TAG_W     = 23;
	localparam int unsigned TAG_LSB   = 9;
	localparam int unsigned WAY_W     = 6;
	localparam int unsigned WAY_LSB   = 9;
	localparam int unsigned SET_W     = 4;
	localparam int unsigned SET_LSB   = 5;
	localparam int unsigned WORD_LSB  = 2;
	localparam int unsigned IDX_W     = WAY_W + SET_W;
	localparam int unsigned LINES     = 1 << IDX_W;
	localparam int unsigned WAYS      = 1 << WAY_W;
	localparam int unsigned LINE_BITS = 256;
	localparam int unsigned WORD_W    = 32;
	localparam int unsigned DW_COUNT  = 4;
	localparam int unsigned LFB_COUNT = 3;
	localparam logic [DW_COUNT-1:0]  DIRTY_NONE = 4'h0;
	localparam logic [DW_COUNT-1:0]  DIRTY_ALL  = 4'hF;
	localparam logic [WAY_W-1:0]     VICTIM_RST = 6'h00;
	localparam logic [ADDR_W-1:0]    ADDR_RST   = 32'h0000_0000;
	localparam logic [LINE_BITS-1:0] LINE_ZERO  = '0;

	typedef enum logic [3:0] {
		OP_ALLOC      = 4'h0,
		OP_FLUSH      = 4'h1,
		OP_INVAL      = 4'h2,
		OP_STORE      = 4'h3,
		OP_TOUCH      = 4'h4,
		OP_TOUCH_ST   = 4'h5,
		OP_ZERO       = 4'h6,
		OP_INVAL_ALL  = 4'h7,
		OP_DEBUG_READ = 4'h8
	} dcache_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOOK = 2'h1,
		ST_CAST = 2'h3,
		ST_FILL = 2'h2
	} ctrl_state_e;
endpackage : dcache_mgmt_pkg
